// file: verilog/tuner_pkg.sv
// Shared constants for the tuner register port: addresses, map, bit positions, timing.
`default_nettype none
package tuner_pkg;
	localparam logic [6:0] TUNER_DEV_ADDR = 7'h60;
	localparam logic [7:0] TUNER_WR_ADDR = 8'hc0;
	localparam logic [7:0] TUNER_RD_ADDR = 8'hc1;
	localparam logic [7:0] TUNER_SUB_PART_IDENTITY = 8'h00;
	localparam logic [7:0] TUNER_SUB_RECEPTION_STATUS = 8'h02;
	localparam logic [7:0] TUNER_SUB_ANTENNA_CAP = 8'h0b;
	localparam logic [7:0] TUNER_SUB_AUDIO_IF = 8'h0d;
	localparam logic [7:0] TUNER_SUB_SOFT_BLEND = 8'h0e;
	localparam logic [7:0] TUNER_SUB_POWER_IRQ = 8'h0f;
	localparam logic [7:0] TUNER_SUB_TUNED_LOW = 8'h10;
	localparam logic [7:0] TUNER_SUB_TUNED_HIGH = 8'h11;
	localparam logic [7:0] TUNER_SUB_REF_PRESCALER = 8'h19;
	localparam logic [7:0] TUNER_SUB_REF_DIVIDER = 8'h1a;
	localparam logic [7:0] TUNER_SUB_REF_OFFSET = 8'h1b;
	localparam logic [7:0] TUNER_SUB_SEEK = 8'h1d;
	localparam logic [7:0] TUNER_SUB_TARGET_LOW = 8'h1e;
	localparam logic [7:0] TUNER_SUB_TARGET_HIGH = 8'h1f;
	localparam int TUNER_MAP_SIZE = 32;
	// Arbitrary identity value, not a real part code
	localparam logic [7:0] TUNER_ID_RESET = 8'h5a;
	localparam logic [7:0] TUNER_REG_RESET = 8'h00;
	localparam int TUNER_POWER_BIT = 0;
	localparam int TUNER_CMD_IE_BIT = 6;
	localparam int TUNER_IRQ_LEVEL_BIT = 7;
	localparam int TUNER_DONE_FLAG_BIT = 4;
	localparam int TUNER_BIT_LAST = 7;
	localparam logic [3:0] TUNER_ACK_SLOT = 4'h8;
	localparam logic [3:0] TUNER_BYTE_DONE = 4'h9;
	// Link clock derivation for the host end; fast-mode rate keeps transactions short
	localparam int TUNER_CLK_HZ = 25000000;
	localparam int TUNER_SCL_HZ = 250000;
	localparam int TUNER_QUARTER = TUNER_CLK_HZ / (TUNER_SCL_HZ * 4);
endpackage
`default_nettype wire

// file: verilog/tuner_link_if.sv
// Two-wire link between the tuner end and the host end, with open-drain resolution.
`default_nettype none
interface tuner_link_if;
	logic scl_o;
	logic scl_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic sda_host_o;
	logic sda_host_oe;
	logic irq_o;
	logic irq_oe;
	logic scl;
	logic sda;
	// Pull-ups: a line is low only where someone drives low
	assign scl = !(scl_oe && !scl_o);
	assign sda = !((sda_dev_oe && !sda_dev_o) || (sda_host_oe && !sda_host_o));
	modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe, output irq_o, output irq_oe);
	modport host (input scl, input sda, input irq_o, input irq_oe, output scl_o, output scl_oe,
		output sda_host_o, output sda_host_oe);
endinterface
`default_nettype wire

// file: verilog/tuner_dev.sv
// Tuner end: two-wire target, register map and interrupt pin.
// What this block does
// - Bytes travel most significant bit first
// - Received bits sampled on clock rise
// - Host holds data steady while clock high
// - Acknowledge driven between eighth and ninth falls
// - Read bits change after fall, host samples rise
// - Host acknowledge sampled on ninth rise
// - Write: address, sub-address, data, stored
// - Only first data byte of write stored
// - Read: sub-address write, restart, read address, data
// - Host ends read with not-acknowledge, stop
// - Start, restart, stop, byte write, byte read
// - Interrupt pin level selectable low or high
// - Interrupt pin floats while power bit cleared
// - Every register eight bits wide
// - Status and identity registers read-only, rest read-write
// - Command done flag set on finish, cleared by read
// - Level select zero high, one low
// - Power bit resets to zero
// - Identity write aborts running command
`default_nettype none
module tuner_dev
	import tuner_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	tuner_link_if.device link,
	input wire logic [7:0] i_reception_status,
	input wire logic [7:0] i_tuned_freq_low,
	input wire logic [7:0] i_tuned_freq_high_status,
	input wire logic i_cmd_done,
	output logic o_cmd_abort,
	output logic o_cmd_start,
	output logic o_radio_power_on_bit,
	output logic [7:0] o_audio_if_control
);
	typedef enum logic [4:0] {
		TUNER_ST_IDLE = 5'b00001,
		TUNER_ST_ADDR = 5'b00010,
		TUNER_ST_RX = 5'b00100,
		TUNER_ST_TX = 5'b01000,
		TUNER_ST_IGNORE = 5'b10000
	} tuner_state_e;
	// Start's own clock fall must not count as a data bit
	localparam logic [3:0] BIT_ARMED = 4'hf;

	// ----------------------------------------
	// Pin synchronisers and edge finding
	// ----------------------------------------
	logic [1:0] scl_sync_q, sda_sync_q;
	logic scl_q, sda_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_sync_q <= {scl_sync_q[0], link.scl};
			sda_sync_q <= {sda_sync_q[0], link.sda};
			scl_q <= scl_sync_q[1];
			sda_q <= sda_sync_q[1];
		end
	end
	logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
	assign scl_s = scl_sync_q[1];
	assign sda_s = sda_sync_q[1];
	assign scl_rise = scl_s && !scl_q;
	assign scl_fall = !scl_s && scl_q;
	// Data moving while clock high marks a frame boundary
	assign start_det = scl_s && scl_q && sda_q && !sda_s;
	assign stop_det = scl_s && scl_q && !sda_q && sda_s;

	// ----------------------------------------
	// Byte engine
	// ----------------------------------------
	tuner_state_e state_q;
	logic [3:0] bit_q;
	logic [7:0] shift_q, sub_q, tx_q;
	logic [1:0] byte_q;
	logic sda_low_q, nack_q, wr_stb, rd_stb;
	logic [7:0] rd_data;
	logic [7:0] regs_q [TUNER_MAP_SIZE];

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= TUNER_ST_IDLE;
			bit_q <= 4'h0;
			shift_q <= 8'h00;
			byte_q <= 2'h0;
			sub_q <= 8'h00;
			tx_q <= 8'h00;
			sda_low_q <= 1'b0;
			nack_q <= 1'b0;
		end else if (start_det) begin
			state_q <= TUNER_ST_ADDR;
			bit_q <= BIT_ARMED;
			byte_q <= 2'h0;
			sda_low_q <= 1'b0;
		end else if (stop_det) begin
			state_q <= TUNER_ST_IDLE;
			sda_low_q <= 1'b0;
		end else begin
			case (state_q)
				TUNER_ST_IDLE, TUNER_ST_IGNORE: begin
					sda_low_q <= 1'b0;
				end
				TUNER_ST_ADDR, TUNER_ST_RX: begin
					if (scl_rise && bit_q < TUNER_ACK_SLOT) begin
						shift_q <= {shift_q[6:0], sda_s};
					end
					if (scl_fall) begin
						if (bit_q == TUNER_ACK_SLOT - 4'h1) begin
							// Ack decided on eighth fall from the completed byte
							if (state_q == TUNER_ST_ADDR && shift_q[7:1] != TUNER_DEV_ADDR) begin
								state_q <= TUNER_ST_IGNORE;
							end else begin
								sda_low_q <= 1'b1;
							end
							bit_q <= TUNER_ACK_SLOT;
						end else if (bit_q == TUNER_ACK_SLOT) begin
							sda_low_q <= 1'b0;
							bit_q <= 4'h0;
							if (state_q == TUNER_ST_ADDR) begin
								if (shift_q[0]) begin
									state_q <= TUNER_ST_TX;
									tx_q <= {rd_data[6:0], 1'b0};
									sda_low_q <= !rd_data[TUNER_BIT_LAST];
								end else begin
									state_q <= TUNER_ST_RX;
								end
							end else begin
								if (byte_q == 2'h0) begin
									sub_q <= shift_q;
								end
								if (byte_q != 2'h3) begin
									byte_q <= byte_q + 2'h1;
								end
							end
						end else begin
							bit_q <= bit_q + 4'h1;
						end
					end
				end
				TUNER_ST_TX: begin
					if (scl_rise && bit_q == TUNER_ACK_SLOT) begin
						nack_q <= sda_s;
					end
					if (scl_fall) begin
						if (bit_q < TUNER_ACK_SLOT - 4'h1) begin
							sda_low_q <= !tx_q[TUNER_BIT_LAST];
							tx_q <= {tx_q[6:0], 1'b0};
							bit_q <= bit_q + 4'h1;
						end else if (bit_q == TUNER_ACK_SLOT - 4'h1) begin
							sda_low_q <= 1'b0;
							bit_q <= TUNER_ACK_SLOT;
						end else begin
							bit_q <= 4'h0;
							// Not-acknowledge ends the read; ack resends the same register
							if (nack_q) begin
								state_q <= TUNER_ST_IGNORE;
							end else begin
								tx_q <= {rd_data[6:0], 1'b0};
								sda_low_q <= !rd_data[TUNER_BIT_LAST];
							end
						end
					end
				end
				default: begin
					state_q <= TUNER_ST_IDLE;
				end
			endcase
		end
	end

	assign link.sda_dev_o = 1'b0;
	assign link.sda_dev_oe = sda_low_q;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	// Third byte of a write is the only data byte that lands
	assign wr_stb = state_q == TUNER_ST_RX && scl_fall && bit_q == TUNER_ACK_SLOT && byte_q == 2'h1;
	assign rd_stb = state_q == TUNER_ST_TX && scl_fall && bit_q == TUNER_ACK_SLOT;

	function automatic logic writable(input logic [7:0] a);
		case (a)
			TUNER_SUB_PART_IDENTITY, TUNER_SUB_ANTENNA_CAP, TUNER_SUB_AUDIO_IF, TUNER_SUB_SOFT_BLEND,
			TUNER_SUB_POWER_IRQ, TUNER_SUB_REF_PRESCALER, TUNER_SUB_REF_DIVIDER, TUNER_SUB_REF_OFFSET,
			TUNER_SUB_SEEK, TUNER_SUB_TARGET_LOW, TUNER_SUB_TARGET_HIGH: writable = 1'b1;
			default: writable = 1'b0;
		endcase
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < TUNER_MAP_SIZE; gi++) begin : g_reg
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					regs_q[gi] <= (gi == 0) ? TUNER_ID_RESET : TUNER_REG_RESET;
				end else if (wr_stb && writable(sub_q) && sub_q == 8'(gi) && 8'(gi) != TUNER_SUB_PART_IDENTITY) begin
					regs_q[gi] <= shift_q;
				end
			end
		end
	endgenerate

	// Identity write is a command abort and leaves the identity unchanged
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_cmd_abort <= 1'b0;
			o_cmd_start <= 1'b0;
		end else begin
			o_cmd_abort <= wr_stb && sub_q == TUNER_SUB_PART_IDENTITY;
			o_cmd_start <= wr_stb && sub_q == TUNER_SUB_TARGET_HIGH;
		end
	end

	logic done_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			done_q <= 1'b0;
		end else if (i_cmd_done) begin
			done_q <= 1'b1;
		end else if (rd_stb && sub_q == TUNER_SUB_TUNED_HIGH) begin
			done_q <= 1'b0;
		end
	end

	always_comb begin
		rd_data = 8'h00;
		case (sub_q)
			TUNER_SUB_RECEPTION_STATUS: rd_data = i_reception_status;
			TUNER_SUB_TUNED_LOW: rd_data = i_tuned_freq_low;
			TUNER_SUB_TUNED_HIGH: begin
				rd_data = i_tuned_freq_high_status;
				rd_data[TUNER_DONE_FLAG_BIT] = done_q;
			end
			default: begin
				if (writable(sub_q) && sub_q < 8'(TUNER_MAP_SIZE)) begin
					rd_data = regs_q[sub_q[4:0]];
				end
			end
		endcase
	end

	// ----------------------------------------
	// Interrupt pin
	// ----------------------------------------
	logic [7:0] ctl;
	logic irq_act;
	assign ctl = regs_q[TUNER_SUB_POWER_IRQ[4:0]];
	assign o_radio_power_on_bit = ctl[TUNER_POWER_BIT];
	assign o_audio_if_control = regs_q[TUNER_SUB_AUDIO_IF[4:0]];
	assign irq_act = done_q && ctl[TUNER_CMD_IE_BIT];
	assign link.irq_o = irq_act ^ ctl[TUNER_IRQ_LEVEL_BIT];
	assign link.irq_oe = ctl[TUNER_POWER_BIT];
endmodule
`default_nettype wire

// file: verilog/tuner_host.sv
// Host end: two-wire controller making single-byte register writes and reads.
`default_nettype none
module tuner_host
	import tuner_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	tuner_link_if.host link,
	input wire logic i_req,
	input wire logic i_write,
	input wire logic [7:0] i_sub,
	input wire logic [7:0] i_wdata,
	output logic o_ready,
	output logic o_done,
	output logic o_nack,
	output logic [7:0] o_rdata,
	output logic o_irq
);
	typedef enum logic [4:0] {
		TH_IDLE = 5'b00001,
		TH_START = 5'b00010,
		TH_BYTE = 5'b00100,
		TH_STOP = 5'b01000,
		TH_END = 5'b10000
	} th_state_e;

	// ----------------------------------------
	// Quarter-period enable and IRQ pin sync
	// ----------------------------------------
	logic [15:0] div_q;
	logic tick;
	assign tick = div_q == 16'(TUNER_QUARTER - 1);
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= tick ? 16'h0000 : div_q + 16'h0001;
		end
	end
	logic [1:0] irq_sync_q, sda_sync_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_sync_q <= 2'h0;
			sda_sync_q <= 2'h3;
		end else begin
			irq_sync_q <= {irq_sync_q[0], link.irq_oe && link.irq_o};
			sda_sync_q <= {sda_sync_q[0], link.sda};
		end
	end
	assign o_irq = irq_sync_q[1];

	// ----------------------------------------
	// Transaction sequencer
	// ----------------------------------------
	th_state_e state_q;
	logic [1:0] ph_q, idx_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic wr_q, scl_q, sda_q, nack_q;
	logic [7:0] sub_q, wd_q;
	logic [7:0] next_byte;
	always_comb begin
		next_byte = 8'h00;
		case (idx_q)
			2'h0: next_byte = sub_q;
			2'h1: next_byte = wr_q ? wd_q : TUNER_RD_ADDR;
			default: next_byte = 8'hff;
		endcase
	end
	assign o_ready = state_q == TH_IDLE;
	assign link.scl_o = 1'b0;
	assign link.scl_oe = !scl_q;
	assign link.sda_host_o = 1'b0;
	assign link.sda_host_oe = !sda_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= TH_IDLE;
			ph_q <= 2'h0;
			idx_q <= 2'h0;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			wr_q <= 1'b0;
			sub_q <= 8'h00;
			wd_q <= 8'h00;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			nack_q <= 1'b0;
			o_done <= 1'b0;
			o_nack <= 1'b0;
			o_rdata <= 8'h00;
		end else begin
			o_done <= 1'b0;
			case (state_q)
				TH_IDLE: begin
					if (i_req) begin
						wr_q <= i_write;
						sub_q <= i_sub;
						wd_q <= i_wdata;
						sh_q <= TUNER_WR_ADDR;
						idx_q <= 2'h0;
						nack_q <= 1'b0;
						ph_q <= 2'h0;
						state_q <= TH_START;
					end
				end
				TH_START: if (tick) begin
					// Quarters: release both, then pull data low with clock high, then clock low
					ph_q <= ph_q + 2'h1;
					case (ph_q)
						2'h0: begin
							sda_q <= 1'b1;
							scl_q <= 1'b1;
						end
						2'h1: sda_q <= 1'b0;
						2'h2: scl_q <= 1'b0;
						default: begin
							bit_q <= 4'h0;
							state_q <= TH_BYTE;
						end
					endcase
				end
				TH_BYTE: if (tick) begin
					ph_q <= ph_q + 2'h1;
					case (ph_q)
						2'h0: begin
							if (bit_q < TUNER_ACK_SLOT) begin
								// Read data bits and the final not-acknowledge release the line
								sda_q <= (idx_q == 2'h3) ? 1'b1 : sh_q[TUNER_BIT_LAST];
								sh_q <= {sh_q[6:0], 1'b0};
							end else begin
								sda_q <= 1'b1;
							end
						end
						2'h1: scl_q <= 1'b1;
						2'h2: begin
							if (bit_q == TUNER_ACK_SLOT) begin
								if (idx_q != 2'h3 && sda_sync_q[1]) begin
									nack_q <= 1'b1;
								end
							end else if (idx_q == 2'h3) begin
								o_rdata <= {o_rdata[6:0], sda_sync_q[1]};
							end
						end
						default: begin
							scl_q <= 1'b0;
							if (bit_q == TUNER_ACK_SLOT) begin
								bit_q <= 4'h0;
								sh_q <= next_byte;
								idx_q <= idx_q + 2'h1;
								// Byte order: address, sub-address, then data or restart, read address, data
								if (idx_q == 2'h3 || (idx_q == 2'h2 && wr_q) || nack_q) begin
									state_q <= TH_STOP;
								end else if (idx_q == 2'h1 && !wr_q) begin
									state_q <= TH_START; // repeated start
								end
							end else begin
								bit_q <= bit_q + 4'h1;
							end
						end
					endcase
				end
				TH_STOP: if (tick) begin
					ph_q <= ph_q + 2'h1;
					case (ph_q)
						2'h0: sda_q <= 1'b0;
						2'h1: scl_q <= 1'b1;
						2'h2: sda_q <= 1'b1;
						default: state_q <= TH_END;
					endcase
				end
				TH_END: begin
					o_done <= 1'b1;
					o_nack <= nack_q;
					state_q <= TH_IDLE;
				end
				default: state_q <= TH_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: bench/tirp_link_assertions.sv
// Checker for the two-wire link between the host end and the tuner end.
`default_nettype none
module tirp_link_assertions
	import tuner_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_sda_dev_oe,
	input wire logic i_sda_host_oe,
	input wire logic i_irq_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// A device pull shorter than most of a bit means a bit cut short
	localparam int MIN_DRIVE = 4 * TUNER_QUARTER - 8;
	int dev_cnt_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dev_cnt_q <= 0;
		end else if (i_sda_dev_oe) begin
			dev_cnt_q <= dev_cnt_q + 1;
		end else begin
			dev_cnt_q <= 0;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// ----------------------------------------
	// Link relations
	// ----------------------------------------
	dev_edge_a: assert property ($changed(i_sda_dev_oe) |-> !i_scl)
		else $error("device data changed while clock high");
	dev_hold_a: assert property ($fell(i_scl) |-> ##1 $stable(i_sda_dev_oe))
		else $error("device data changed right at clock fall");
	ack_len_a: assert property ($rose(i_sda_dev_oe) |-> i_sda_dev_oe [*8])
		else $error("device pull shorter than eight cycles");
	dev_span_a: assert property ($fell(i_sda_dev_oe) |-> dev_cnt_q >= MIN_DRIVE)
		else $error("device pull released before a full bit");
	start_fall_a: assert property (i_scl && $rose(i_sda_host_oe) |-> ##[1:150] !i_scl)
		else $error("clock did not fall after start");
	stop_idle_a: assert property (i_scl && $fell(i_sda_host_oe) |-> i_scl [*8])
		else $error("clock not idle after stop");
	no_clash_a: assert property (i_sda_dev_oe && i_scl |-> !i_sda_host_oe)
		else $error("host pulls data while device bit sampled");
	irq_float_a: assert property ($rose(i_rst_n) |-> !i_irq_oe [*8])
		else $error("interrupt pin driven after reset");
	dev_quiet_a: assert property (i_scl && $past(i_scl) && $changed(i_sda) |-> !$past(i_sda_dev_oe))
		else $error("device moved data line while clock high");
endmodule
`default_nettype wire

// file: bench/tuner_i2c_register_port_tb.sv
// Testbench: host end and tuner end joined, register traffic from the host user side.
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin err_total++; \
	$display("Error %s expected %h seen %h", nm, exp, got); end end
module tuner_i2c_register_port_tb import tuner_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TIMEOUT = 90000;
	logic i_clk, i_rst_n, i_req, i_write, i_cmd_done;
	logic [7:0] i_sub, i_wdata, i_status, i_tlow, i_thigh;
	logic o_ready, o_done, o_nack, o_irq, o_abort, o_power, o_start;
	logic [7:0] o_rdata, o_audio;
	int err_total, check_count, abort_cnt, start_cnt, cycles;

	tuner_link_if tuner_link_if_inst ();
	tuner_dev tuner_dev_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(tuner_link_if_inst.device),
		.i_reception_status(i_status), .i_tuned_freq_low(i_tlow), .i_tuned_freq_high_status(i_thigh),
		.i_cmd_done(i_cmd_done), .o_cmd_abort(o_abort), .o_cmd_start(o_start), .o_radio_power_on_bit(o_power),
		.o_audio_if_control(o_audio));
	tuner_host tuner_host_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(tuner_link_if_inst.host),
		.i_req(i_req), .i_write(i_write), .i_sub(i_sub), .i_wdata(i_wdata), .o_ready(o_ready),
		.o_done(o_done), .o_nack(o_nack), .o_rdata(o_rdata), .o_irq(o_irq));
	tirp_link_assertions tirp_link_assertions_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_scl(tuner_link_if_inst.scl), .i_sda(tuner_link_if_inst.sda),
		.i_sda_dev_oe(tuner_link_if_inst.sda_dev_oe), .i_sda_host_oe(tuner_link_if_inst.sda_host_oe),
		.i_irq_oe(tuner_link_if_inst.irq_oe));

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic host_op(input logic wr, input logic [7:0] sub, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge i_clk);
		`CHK("ready", 1'b1, o_ready)
		i_req <= 1'b1;
		i_write <= wr;
		i_sub <= sub;
		i_wdata <= wd;
		@(posedge i_clk);
		i_req <= 1'b0;
		@(posedge i_clk);
		`CHK("busy", 1'b0, o_ready)
		while (o_done !== 1'b1 && n < 20000) begin
			@(posedge i_clk);
			n++;
		end
		`CHK("done", 1'b1, o_done)
		`CHK("ready again", 1'b1, o_ready)
		`CHK("nack", 1'b0, o_nack)
	endtask

	task automatic read_chk(input logic [7:0] sub, input logic [7:0] exp);
		host_op(1'b0, sub, 8'h00);
		`CHK("rdata", exp, o_rdata)
	endtask

	task automatic pulse_done();
		@(posedge i_clk);
		i_cmd_done <= 1'b1;
		@(posedge i_clk);
		i_cmd_done <= 1'b0;
		// Pin goes through the flag and the host synchroniser
		repeat (8) @(posedge i_clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		read_chk(TUNER_SUB_POWER_IRQ, 8'h00);
		`CHK("power", 1'b0, o_power)
		`CHK("irq_oe", 1'b0, tuner_link_if_inst.irq_oe)
		$display("Test reset values done");
	endtask

	task automatic t_abort();
		host_op(1'b1, TUNER_SUB_PART_IDENTITY, 8'ha5);
		`CHK("abort", 1, abort_cnt)
		read_chk(TUNER_SUB_PART_IDENTITY, TUNER_ID_RESET);
		$display("Test abort done");
	endtask

	task automatic t_rw();
		// Asymmetric byte so a reversed bit order shows
		host_op(1'b1, TUNER_SUB_AUDIO_IF, 8'hc5);
		`CHK("audio", 8'hc5, o_audio)
		`CHK("no abort", 1, abort_cnt)
		read_chk(TUNER_SUB_AUDIO_IF, 8'hc5);
		$display("Test write and read done");
	endtask

	task automatic t_ro();
		host_op(1'b1, TUNER_SUB_RECEPTION_STATUS, 8'hff);
		read_chk(TUNER_SUB_RECEPTION_STATUS, 8'h4b);
		host_op(1'b1, 8'h05, 8'h77);
		read_chk(8'h05, 8'h00);
		$display("Test read-only and unmapped done");
	endtask

	task automatic t_start();
		host_op(1'b1, TUNER_SUB_TARGET_HIGH, 8'h3c);
		`CHK("start", 1, start_cnt)
		read_chk(TUNER_SUB_TARGET_HIGH, 8'h3c);
		$display("Test command start done");
	endtask

	task automatic t_irq();
		host_op(1'b1, TUNER_SUB_POWER_IRQ, 8'h41);
		`CHK("power", 1'b1, o_power)
		`CHK("driven", 1'b1, tuner_link_if_inst.irq_oe)
		`CHK("idle high pol", 1'b0, tuner_link_if_inst.irq_o)
		pulse_done();
		`CHK("active high", 1'b1, tuner_link_if_inst.irq_o)
		`CHK("host irq", 1'b1, o_irq)
		read_chk(TUNER_SUB_TUNED_HIGH, 8'hb3);
		read_chk(TUNER_SUB_TUNED_HIGH, 8'ha3);
		`CHK("cleared", 1'b0, tuner_link_if_inst.irq_o)
		host_op(1'b1, TUNER_SUB_POWER_IRQ, 8'hc1);
		`CHK("idle low pol", 1'b1, tuner_link_if_inst.irq_o)
		pulse_done();
		`CHK("active low", 1'b0, tuner_link_if_inst.irq_o)
		$display("Test interrupt done");
	endtask

	// ----------------------------------------
	// Clock, monitors, main sequence
	// ----------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		cycles++;
		if (o_abort === 1'b1) begin
			abort_cnt++;
		end
		if (o_start === 1'b1) begin
			start_cnt++;
		end
		if (cycles == TIMEOUT) begin
			err_total++;
			report_and_stop();
		end
	end

	initial begin
		{i_rst_n, i_req, i_write, i_cmd_done} = 4'h0;
		{i_sub, i_wdata, i_tlow} = 24'h000000;
		i_status = 8'h4b;
		i_thigh = 8'ha3;
		repeat (10) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_reset();
		t_abort();
		t_rw();
		t_ro();
		t_start();
		t_irq();
		report_and_stop();
	end
endmodule
`undef CHK
`default_nettype wire
